// *** periodic_down_timer.sv ***
// Periodic down-counter timer with register port and timeout interrupt
`timescale 1ns/10ps

// Function
// - At zero, reload from modulus if reload set, else wrap to ffff.
// - Enable low holds counter and prescaler stopped; enable always writable.
// - Sixteen-bit read/write modulus register, resets to ffff.
// - With immediate load set, modulus write loads counter at once.
// - Prescaler cleared on every counter load and during reset.
// - Modulus read returns the latched modulus, not the count.
// - Count register is read-only; writes ignored but complete normally.
// - Reload mode: at zero set flag, load modulus, keep counting down.
// - Free mode: at zero set flag, wrap to ffff, keep counting.
// - Flag with interrupt enable raises interrupt; no enable, no request.
// - Flag cleared by writing one or writing modulus; zero no effect.
// - Reload mode period is divisor times (modulus plus one) clock cycles.
// - Without immediate load, modulus write waits for next zero.
module periodic_down_timer #(
  parameter int DATA_W = timer_pkg::DATA_W,
  parameter int PRE_W = timer_pkg::PRE_W
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Register port
  input wire timer_pkg::bus_req_type bus_req,
  output logic [15:0] rd_data_q,
  // Interrupt request
  output logic irq_q
);

  // ***********************************************************
  // Elaboration checks
  // ***********************************************************
  if (DATA_W != 16)
    $error("periodic_down_timer: data width must be 16");
  if (PRE_W != 4)
    $error("periodic_down_timer: prescale field must be 4 bits");

  // ***********************************************************
  // State
  // ***********************************************************
  timer_pkg::ctrl_type ctrl_q;
  timer_pkg::ctrl_type ctrl_d;
  logic [15:0] modulus_q;
  logic [15:0] modulus_d;
  logic [15:0] count_q;
  logic [15:0] count_d;
  logic flag_q;
  logic flag_d;
  logic [15:0] rd_data_d;
  logic irq_d;

  // ***********************************************************
  // Address decode
  // ***********************************************************
  logic sel_ctrl;
  logic sel_mod;
  logic sel_cnt;
  logic sel_ist;
  logic sel_imsk;
  logic wr_ctrl;
  logic wr_mod;
  logic wr_cnt;
  logic wr_ist;
  logic wr_imsk;
  logic rd_any;

  // Full byte address compare; other offsets read as zero
  assign sel_ctrl = bus_req.addr == timer_pkg::OFS_CONTROL_STATUS;
  assign sel_mod = bus_req.addr == timer_pkg::OFS_MODULUS;
  assign sel_cnt = bus_req.addr == timer_pkg::OFS_COUNT_VALUE;
  assign sel_ist = bus_req.addr == timer_pkg::OFS_IRQ_STATUS;
  assign sel_imsk = bus_req.addr == timer_pkg::OFS_IRQ_MASK;
  assign wr_ctrl = bus_req.wr & sel_ctrl;
  assign wr_mod = bus_req.wr & sel_mod;
  assign wr_cnt = bus_req.wr & sel_cnt;
  assign wr_ist = bus_req.wr & sel_ist;
  assign wr_imsk = bus_req.wr & sel_imsk;
  assign rd_any = bus_req.rd;

  // ***********************************************************
  // Control fields
  // ***********************************************************
  logic [15:0] wd;
  logic mask_wr_val;

  assign wd = bus_req.wdata;
  assign mask_wr_val = wd[timer_pkg::BIT_TIMEOUT_EVT];

  // The mask register aliases the interrupt enable bit
  always_comb
  begin
    ctrl_d = ctrl_q;
    if (wr_ctrl)
    begin
      ctrl_d.enable = wd[timer_pkg::BIT_ENABLE];
      ctrl_d.reload = wd[timer_pkg::BIT_RELOAD];
      ctrl_d.irq_en = wd[timer_pkg::BIT_IRQ_EN];
      ctrl_d.imm_load = wd[timer_pkg::BIT_IMM_LOAD];
      ctrl_d.pre = wd[timer_pkg::PRE_MSB:timer_pkg::PRE_LSB];
    end
    else if (wr_imsk)
    begin
      ctrl_d.irq_en = mask_wr_val;
    end
  end

  // Control register
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      ctrl_q <= '0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
    end
  end

  // ***********************************************************
  // Modulus latch
  // ***********************************************************
  // Every write updates the latch, with or without immediate load
  assign modulus_d = wr_mod ? wd : modulus_q;

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      modulus_q <= timer_pkg::MODULUS_RST;
    end
    else
    begin
      modulus_q <= modulus_d;
    end
  end

  // ***********************************************************
  // Prescaler
  // ***********************************************************
  logic tick;
  logic zero_hit;
  logic imm_load;
  logic pre_clear;

  // Immediate load only when the mode bit is already set
  assign imm_load = wr_mod & ctrl_q.imm_load;
  assign zero_hit = tick & (count_q == timer_pkg::COUNT_ZERO);
  // Any counter load restarts the prescaler period
  assign pre_clear = imm_load | zero_hit;

  prescale_divider #(
    .CNT_W(16),
    .SEL_W(PRE_W)
  ) u_prescale (
    .core_clk(core_clk),
    .reset(reset),
    .run(ctrl_q.enable),
    .clear(pre_clear),
    .sel(ctrl_q.pre),
    .tick(tick)
  );

  // ***********************************************************
  // Down-counter
  // ***********************************************************
  logic [15:0] zero_next;
  logic [15:0] dec_val;

  // Reload from the latch or wrap without touching it
  assign zero_next = ctrl_q.reload ? modulus_q :
                     timer_pkg::COUNT_WRAP;
  assign dec_val = count_q - timer_pkg::COUNT_STEP;

  // Immediate load outranks a tick in the same cycle
  always_comb
  begin
    count_d = count_q;
    if (imm_load)
    begin
      count_d = wd;
    end
    else if (zero_hit)
    begin
      count_d = zero_next;
    end
    else if (tick)
    begin
      count_d = dec_val;
    end
  end

  // Count register; writes to its offset are dropped
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      count_q <= timer_pkg::COUNT_RST;
    end
    else
    begin
      count_q <= count_d;
    end
  end

  // ***********************************************************
  // Timeout flag
  // ***********************************************************
  logic flag_clr;

  // A zero crossing in the clearing cycle still sets the flag
  assign flag_clr = (wr_ctrl & wd[timer_pkg::BIT_FLAG]) |
                    (wr_ist & wd[timer_pkg::BIT_TIMEOUT_EVT]) |
                    wr_mod;
  assign flag_d = zero_hit | (flag_q & ~flag_clr);

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      flag_q <= 1'b0;
    end
    else
    begin
      flag_q <= flag_d;
    end
  end

  // ***********************************************************
  // Read data and interrupt
  // ***********************************************************
  logic [15:0] ctrl_rd;
  logic [15:0] sel_rd;

  // Reserved bits read back as zero
  assign ctrl_rd = {4'h0, ctrl_q.pre, 3'h0, ctrl_q.imm_load,
                    ctrl_q.irq_en, flag_q, ctrl_q.reload, ctrl_q.enable};
  assign sel_rd = sel_ctrl ? ctrl_rd :
                  sel_mod ? modulus_q :
                  sel_cnt ? count_q :
                  sel_ist ? {15'h0000, flag_q} :
                  sel_imsk ? {15'h0000, ctrl_q.irq_en} :
                  timer_pkg::READ_ZERO;
  // Data stand only in the cycle after the strobe
  assign rd_data_d = rd_any ? sel_rd : timer_pkg::READ_ZERO;
  assign irq_d = flag_q & ctrl_q.irq_en;

  // Registered outputs
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      rd_data_q <= timer_pkg::READ_ZERO;
      irq_q <= 1'b0;
    end
    else
    begin
      rd_data_q <= rd_data_d;
      irq_q <= irq_d;
    end
  end

  // ***********************************************************
  // Checks
  // ***********************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  AST_RELOAD_LOAD: assert property (
    zero_hit && ctrl_q.reload && !imm_load
    |=> count_q == $past(modulus_q))
    else $error("reload did not load the modulus");

  AST_FREE_WRAP: assert property (
    zero_hit && !ctrl_q.reload && !imm_load
    |=> count_q == timer_pkg::COUNT_WRAP && flag_q)
    else $error("free run did not wrap with flag");

  AST_DISABLED_HOLD: assert property (
    !ctrl_q.enable && !imm_load |=> $stable(count_q))
    else $error("counter moved while disabled");

  AST_MOD_STORE: assert property (
    wr_mod |=> modulus_q == $past(wd))
    else $error("modulus latch not written");

  AST_IMM_LOAD: assert property (
    wr_mod && ctrl_q.imm_load |=> count_q == $past(wd))
    else $error("immediate load missed");

  AST_MOD_READ: assert property (
    bus_req.rd && sel_mod |=> rd_data_q == $past(modulus_q))
    else $error("modulus read wrong");

  AST_COUNT_RO: assert property (
    wr_cnt && !tick |=> count_q == $past(count_q))
    else $error("count register took a write");

  AST_FLAG_SET: assert property (
    zero_hit ##1 !flag_clr |=> flag_q)
    else $error("timeout flag lost");

  AST_IRQ_GATE: assert property (
    !ctrl_q.irq_en [*2] |-> !irq_q)
    else $error("interrupt without enable");

  AST_FLAG_CLEAR: assert property (
    flag_clr && !zero_hit |=> !flag_q)
    else $error("timeout flag not cleared");

  AST_NO_IMM_WAIT: assert property (
    wr_mod && !ctrl_q.imm_load && !tick
    |=> count_q == $past(count_q))
    else $error("modulus write disturbed count");

  AST_DECREMENT: assert property (
    tick && !zero_hit && !imm_load
    |=> count_q == $past(count_q) - timer_pkg::COUNT_STEP)
    else $error("count did not step down by one");

  AST_SET_WINS: assert property (
    zero_hit |=> flag_q)
    else $error("clear beat a zero crossing");

  AST_IRQ_RAISE: assert property (
    flag_q && ctrl_q.irq_en |=> irq_q)
    else $error("enabled flag gave no interrupt");

  AST_IRQ_DROP: assert property (
    !flag_q |=> !irq_q)
    else $error("interrupt without a flag");

  AST_COUNT_READ: assert property (
    bus_req.rd && sel_cnt |=> rd_data_q == $past(count_q))
    else $error("count read wrong");

  AST_FREE_KEEP_MOD: assert property (
    zero_hit && !ctrl_q.reload && !wr_mod |=> $stable(modulus_q))
    else $error("free run touched the modulus latch");

endmodule : periodic_down_timer

// *** timer_pkg.sv ***
// Shared constants and carrier types for the periodic down-counter timer
package timer_pkg;

  // ***********************************************************
  // Widths
  // ***********************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int PRE_W = 4;

  // ***********************************************************
  // Register byte offsets
  // ***********************************************************
  localparam logic [7:0] OFS_CONTROL_STATUS = 8'h00;
  localparam logic [7:0] OFS_MODULUS = 8'h04;
  localparam logic [7:0] OFS_COUNT_VALUE = 8'h08;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h0c;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;

  // ***********************************************************
  // Field positions in the control/status register and interrupt status/mask registers
  // ***********************************************************
  localparam int BIT_ENABLE = 0;
  localparam int BIT_RELOAD = 1;
  localparam int BIT_FLAG = 2;
  localparam int BIT_IRQ_EN = 3;
  localparam int BIT_IMM_LOAD = 4;
  localparam int PRE_LSB = 8;
  localparam int PRE_MSB = 11;
  localparam int BIT_TIMEOUT_EVT = 0;

  // ***********************************************************
  // Values after reset and fixed count values
  // ***********************************************************
  localparam logic [15:0] MODULUS_RST = 16'hffff;
  localparam logic [15:0] COUNT_RST = 16'hffff;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [15:0] COUNT_WRAP = 16'hffff;
  localparam logic [15:0] COUNT_STEP = 16'h0001;
  localparam logic [3:0] PRE_RST = 4'h0;
  localparam logic [15:0] READ_ZERO = 16'h0000;

  // ***********************************************************
  // Carrier types
  // ***********************************************************
  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } bus_req_type;

  typedef struct packed {
    logic [3:0] pre;
    logic imm_load;
    logic irq_en;
    logic reload;
    logic enable;
  } ctrl_type;

endpackage : timer_pkg

// *** prescale_divider.sv ***
// Power-of-two prescaler giving a one-cycle enable pulse
`timescale 1ns/10ps

module prescale_divider #(
  parameter int CNT_W = 16,
  parameter int SEL_W = 4
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Control
  input wire logic run,
  input wire logic clear,
  input wire logic [SEL_W-1:0] sel,
  // Divided enable pulse
  output logic tick
);

  // ***********************************************************
  // Divider state
  // ***********************************************************
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [CNT_W-1:0] mask;

  if (CNT_W < (1 << SEL_W) - 1)
    $error("prescale_divider: counter too narrow for select range");

  // Low sel bits all ones marks the last cycle of a 2^sel period
  assign mask = CNT_W'((1 << sel) - 1);
  assign tick = run & ((cnt_q & mask) == mask);
  assign cnt_d = clear ? '0 : (run ? cnt_q + CNT_W'(1) : cnt_q);

  // Count held while stopped, zeroed on every counter load
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      cnt_q <= '0;
    end
    else
    begin
      cnt_q <= cnt_d;
    end
  end

  // ***********************************************************
  // Checks
  // ***********************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  AST_PRE_CLEAR: assert property (
    clear |=> cnt_q == '0)
    else $error("prescaler not cleared on load");

  AST_DIV_TWO: assert property (
    tick && run && !clear && sel == SEL_W'(1) |=> !tick)
    else $error("divide by two gave back to back ticks");

endmodule : prescale_divider

// *** periodic_down_timer_tb.sv ***
// Self-checking testbench for the periodic down-counter timer
`timescale 1ns/10ps

module periodic_down_timer_tb;
  // ***********************************************************
  // Signals and table rows
  // ***********************************************************
  typedef struct packed {
    logic [3:0] pre;
    logic [15:0] modv;
    logic reload_select;
    logic [15:0] cycles;
    logic wraps;
  } row_type;
  localparam logic [7:0] A_CS = timer_pkg::OFS_CONTROL_STATUS;
  localparam logic [7:0] A_MOD = timer_pkg::OFS_MODULUS;
  localparam logic [7:0] A_CNT = timer_pkg::OFS_COUNT_VALUE;
  localparam logic [7:0] A_IST = timer_pkg::OFS_IRQ_STATUS;
  localparam logic [7:0] A_IMSK = timer_pkg::OFS_IRQ_MASK;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  timer_pkg::bus_req_type req = '0;
  logic [15:0] rd_data_q;
  logic irq_q;
  logic [15:0] v;
  logic [15:0] a;
  int err_total = 0;
  int check_count = 0;
  int n;
  row_type rows [4];
  row_type r;

  // Half period of 10 ns gives 50 MHz
  always #10 core_clk = ~core_clk;

  periodic_down_timer dut_u (
    .core_clk(core_clk),
    .reset(reset),
    .bus_req(req),
    .rd_data_q(rd_data_q),
    .irq_q(irq_q)
  );

  // ***********************************************************
  // Bus and compare helpers
  // ***********************************************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] ad, input logic [15:0] d);
    @(posedge core_clk);
    req.wr <= 1'b1;
    req.addr <= ad;
    req.wdata <= d;
    @(posedge core_clk);
    req.wr <= 1'b0;
  endtask : wr

  // Data stand only in the cycle after the strobe, so sample just then
  task automatic rd(input logic [7:0] ad, output logic [15:0] d);
    @(posedge core_clk);
    req.rd <= 1'b1;
    req.addr <= ad;
    @(posedge core_clk);
    req.rd <= 1'b0;
    #1;
    d = rd_data_q;
  endtask : rd

  task automatic rdchk(input logic [7:0] ad, input logic [15:0] exp);
    logic [15:0] d;
    rd(ad, d);
    chk(d, exp);
  endtask : rdchk

  function automatic logic [15:0] ctl(input logic en, input logic rl,
    input logic ie, input logic im, input logic [3:0] p, input logic fl);
    logic [15:0] c;
    c = '0;
    c[timer_pkg::BIT_ENABLE] = en;
    c[timer_pkg::BIT_RELOAD] = rl;
    c[timer_pkg::BIT_IRQ_EN] = ie;
    c[timer_pkg::BIT_IMM_LOAD] = im;
    c[timer_pkg::BIT_FLAG] = fl;
    c[timer_pkg::PRE_MSB:timer_pkg::PRE_LSB] = p;
    return c;
  endfunction : ctl

  task automatic results;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : results

  // ***********************************************************
  // Main sequence
  // ***********************************************************
  initial
  begin
    // Cycles: 2^pre * (modulus + 1) to the flag, one more to the interrupt
    rows[0] = '{4'h0, 16'h0003, 1'b1, 16'h0005, 1'b0};
    rows[1] = '{4'h1, 16'h0004, 1'b0, 16'h000b, 1'b1};
    rows[2] = '{4'h2, 16'h0002, 1'b1, 16'h000d, 1'b0};
    rows[3] = '{4'h0, 16'h0000, 1'b1, 16'h0002, 1'b0};
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    // Each row: load at once, time the first timeout, then clear
    foreach (rows[i])
    begin
      r = rows[i];
      wr(A_CS, ctl(1'b0, r.reload_select, 1'b1, 1'b1, r.pre, 1'b0));
      wr(A_MOD, r.modv);
      rdchk(A_CNT, r.modv);
      wr(A_CS, ctl(1'b1, r.reload_select, 1'b1, 1'b1, r.pre, 1'b0));
      n = 0;
      do
      begin
        @(posedge core_clk);
        #1;
        n++;
      end
      while (irq_q !== 1'b1 && n < 5000);
      chk(16'(n), r.cycles);
      rd(A_CNT, v);
      chk({15'h0000, v > r.modv}, {15'h0000, r.wraps});
      wr(A_CS, ctl(1'b0, r.reload_select, 1'b1, 1'b1, r.pre, 1'b0));
      rdchk(A_IST, 16'h0001);
      wr(A_IMSK, 16'h0000);
      repeat (2) @(posedge core_clk);
      #1;
      chk({15'h0000, irq_q}, 16'h0000);
      // Free-run rows clear through the control register's flag bit
      if (r.reload_select)
        wr(A_IST, 16'h0001);
      else
        wr(A_CS, ctl(1'b0, r.reload_select, 1'b0, 1'b1, r.pre, 1'b1));
      rdchk(A_IST, 16'h0000);
    end
    // Disable must freeze the count, and enable reads back
    wr(A_CS, ctl(1'b0, 1'b1, 1'b0, 1'b1, 4'h0, 1'b0));
    wr(A_MOD, 16'h0064);
    wr(A_CS, ctl(1'b1, 1'b1, 1'b0, 1'b1, 4'h0, 1'b0));
    repeat (10) @(posedge core_clk);
    wr(A_CS, ctl(1'b0, 1'b1, 1'b0, 1'b0, 4'h0, 1'b0));
    rd(A_CNT, a);
    repeat (10) @(posedge core_clk);
    rdchk(A_CNT, a);
    chk({15'h0000, a < 16'h0064}, 16'h0001);
    rdchk(A_CS, ctl(1'b0, 1'b1, 1'b0, 1'b0, 4'h0, 1'b0));
    // Late modulus write leaves the running count alone
    wr(A_CS, ctl(1'b1, 1'b1, 1'b0, 1'b0, 4'h0, 1'b0));
    wr(A_MOD, 16'h0005);
    rd(A_CNT, v);
    chk({15'h0000, v > 16'h0005}, 16'h0001);
    rdchk(A_MOD, 16'h0005);
    wr(A_CNT, 16'h0000);
    rd(A_CNT, v);
    chk({15'h0000, v > 16'h0005}, 16'h0001);
    rdchk(8'h14, 16'h0000);
    // Past the zero crossing the new modulus is in use
    repeat (120) @(posedge core_clk);
    rd(A_CNT, v);
    chk({15'h0000, v < 16'h0006}, 16'h0001);
    wr(A_CS, ctl(1'b0, 1'b1, 1'b0, 1'b0, 4'h0, 1'b0));
    rdchk(A_IST, 16'h0001);
    wr(A_MOD, 16'h0007);
    rdchk(A_IST, 16'h0000);
    // Second reset in mid-run, with interrupt pending
    wr(A_CS, ctl(1'b1, 1'b1, 1'b1, 1'b0, 4'h0, 1'b0));
    repeat (12) @(posedge core_clk);
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    #1;
    chk({15'h0000, irq_q}, 16'h0000);
    rdchk(A_MOD, timer_pkg::MODULUS_RST);
    rdchk(A_CNT, timer_pkg::COUNT_RST);
    rdchk(A_CS, 16'h0000);
    results();
  end

  // Watchdog: the whole run needs well under a thousand cycles
  initial
  begin
    #400000;
    err_total++;
    results();
  end
endmodule : periodic_down_timer_tb
